// ===== atg_pkg.sv
/*
  shared constants, register map and state types of the
  acquisition trigger gate.
  assumes a 100 MHz mclk and 32-bit apb data.
*/
`default_nettype none
package atg_pkg;
  // ==========================================================
  // clock and timing
  localparam int CLK_NS = 10;
  localparam int US_NS = 1000;
  localparam int SEC_NS = 1000000000;
  localparam int CYC_PER_US = US_NS / CLK_NS;
  localparam int CLK_HZ = SEC_NS / CLK_NS;
  localparam int TW = 36; // time counter width
  localparam int DW = 32; // divider width
  localparam int CYC_W = 7; // width of cycles per us

  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_EXPO = 8'h04;
  localparam logic [7:0] A_TBASE = 8'h08;
  localparam logic [7:0] A_ROI = 8'h0C;
  localparam logic [7:0] A_C1 = 8'h10;
  localparam logic [7:0] A_C2 = 8'h14;
  localparam logic [7:0] A_RATE = 8'h18;
  localparam logic [7:0] A_STAT = 8'h1C;
  localparam logic [7:0] A_DROP = 8'h20;

  // ==========================================================
  // field positions
  localparam int C_HW = 0;
  localparam int C_NOV = 1;
  localparam int C_RATE = 2;
  localparam int C_LINE = 4;
  localparam int LINE_W = 2;
  localparam int N_LINES = 4;

  // ==========================================================
  // reset values and minimum writable values
  localparam logic [1:0] RST_LINE = 2'h2;
  localparam logic [11:0] RST_RAW = 12'h001;
  localparam logic [11:0] RAW_MIN = 12'h001;
  localparam logic [15:0] RST_TBASE = 16'h0014;
  localparam logic [15:0] TBASE_MIN = 16'h0001;
  localparam logic [11:0] RST_ROI = 12'h1E0;
  localparam logic [15:0] RST_C1 = 16'h0064;
  localparam logic [15:0] RST_C2 = 16'h03E8;
  localparam logic [15:0] RST_RATE = 16'h000A;

  // ==========================================================
  // state of the gate
  typedef struct packed {
    logic [2:0] sync;
    logic hw_en;
    logic no_ovl;
    logic rate_en;
    logic [LINE_W-1:0] line_sel;
    logic [11:0] raw;
    logic [15:0] tbase;
    logic [11:0] roi;
    logic [15:0] c1;
    logic [15:0] c2;
    logic [15:0] rate;
    logic permit;
    logic [N_LINES-1:0] out_line;
    logic [15:0] drops;
    logic ovl;
    logic [TW-1:0] per_cnt;
    logic [TW-1:0] prev_len;
    logic [31:0] prdata;
    logic pslverr;
    logic div_go;
  } atg_st_t;
endpackage
`default_nettype wire

// ===== atg_tmr.sv
/*
  loadable down counter used for exposure, readout and pacing.
  assumes load and value come from logic on mclk.
*/
`timescale 1ns/1ps
`default_nettype none
module atg_tmr #(
  parameter int W = 36
) (
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // control
  input wire logic load,
  input wire logic [W-1:0] value,
  // state
  output logic [W-1:0] cnt
);
  typedef struct packed {
    logic [W-1:0] cnt;
  } atg_tmr_st_t;

  atg_tmr_st_t q, d;

  generate
    if (W < 2) begin : g_chk
      $error("atg_tmr width too small");
    end
  endgenerate

  // ==========================================================
  // count down to zero, reload on request
  always_comb begin
    d = q;
    if (load) begin
      d.cnt = value;
    end else if (q.cnt != '0) begin
      d.cnt = q.cnt - W'(1);
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign cnt = q.cnt;
endmodule
`default_nettype wire

// ===== atg_div.sv
/*
  restoring divider: quotient of a fixed dividend by divisor.
  assumes go is a one-cycle pulse; result holds until next go.
*/
`timescale 1ns/1ps
`default_nettype none
module atg_div #(
  parameter int W = 32,
  parameter logic [31:0] DIVIDEND = 32'h05F5E100
) (
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // request
  input wire logic go,
  input wire logic [W-1:0] divisor,
  // result
  output logic [W-1:0] quo,
  output logic busy
);
  typedef struct packed {
    logic [W:0] rem;
    logic [W-1:0] q;
    logic [5:0] step;
    logic busy;
  } atg_div_st_t;

  atg_div_st_t q, d;
  logic [W:0] trial;

  generate
    if (W < 2 || W > 32) begin : g_chk
      $error("atg_div width out of range");
    end
  endgenerate

  // ==========================================================
  // one quotient bit per cycle, msb first
  always_comb begin
    d = q;
    trial = {q.rem[W-1:0], q.q[W-1]};
    if (go) begin
      d.rem = '0;
      d.q = DIVIDEND[W-1:0];
      d.step = 6'(W);
      d.busy = 1'b1;
    end else if (q.busy) begin
      if (trial >= {1'b0, divisor}) begin
        d.rem = trial - {1'b0, divisor};
        d.q = {q.q[W-2:0], 1'b1};
      end else begin
        d.rem = trial;
        d.q = {q.q[W-2:0], 1'b0};
      end
      d.step = q.step - 6'h01;
      d.busy = (q.step != 6'h01);
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign quo = q.q;
  assign busy = q.busy;
endmodule
`default_nettype wire

// ===== atg_gate.sv
/*
  acquisition trigger gate: qualifies hardware triggers against
  exposure and readout state, drives the permit output and routes
  it to an output line; registers over apb.
  assumes trig_in is asynchronous, apb on mclk, 100 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - period <= exposure+readout flags overlapped frame
// - longer period flags a non-overlapped frame
// - no mode bit; overlap follows trigger timing
// - drop triggers breaking either overlap constraint
// - no-overlap variant waits for readout end
// - permit high when safe, low after start
// - permit rise from exposure, roi, readout
// - frame-rate limit paces permit rises exactly
// - too-high rate limit yields the natural maximum
// - starts while permit low are ignored
// - permit only while hardware triggering enabled
// - permit routed to line 2, reassignable
// - exposure is raw count times time base
// - readout is height times c1 plus c2
module atg_gate #(
  parameter int TW = atg_pkg::TW
) (
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // trigger pin and outputs
  input wire logic trig_in,
  output logic acq_permit_out,
  output logic [atg_pkg::N_LINES-1:0] out_line,
  output logic exp_active,
  output logic ro_active
);
  atg_pkg::atg_st_t q, d;
  logic [TW-1:0] exp_cnt, ro_cnt, pace_cnt;
  logic [TW-1:0] exp_len, ro_len, pace_val;
  logic [atg_pkg::DW-1:0] quo;
  logic div_busy;
  logic trig_edge, acq_start, pace_on, safe, hit, wr_acc;
  logic ro_load;
  logic pace_ok, pace_load, permit_nx, hw_off;
  logic [31:0] rdata;

  localparam logic [atg_pkg::CYC_W-1:0] CYC_W_ONE =
    atg_pkg::CYC_W'(atg_pkg::CYC_PER_US);

  generate
    if (TW < atg_pkg::TW) begin : g_chk
      $error("atg_gate time width too small");
    end
  endgenerate

  // ==========================================================
  // timers and rate divider
  atg_tmr #(.W(TW)) u_exp (
    .mclk(mclk),
    .arst_n(arst_n),
    .load(acq_start),
    .value(exp_len),
    .cnt(exp_cnt)
  );

  atg_tmr #(.W(TW)) u_ro (
    .mclk(mclk),
    .arst_n(arst_n),
    .load(ro_load),
    .value(ro_len),
    .cnt(ro_cnt)
  );

  atg_tmr #(.W(TW)) u_pace (
    .mclk(mclk),
    .arst_n(arst_n),
    .load(pace_load),
    .value(pace_val),
    .cnt(pace_cnt)
  );

  atg_div #(
    .W(atg_pkg::DW),
    .DIVIDEND(32'(atg_pkg::CLK_HZ))
  ) u_div (
    .mclk(mclk),
    .arst_n(arst_n),
    .go(q.div_go),
    .divisor(32'(q.rate)),
    .quo(quo),
    .busy(div_busy)
  );

  // ==========================================================
  // durations and safe-start decision
  always_comb begin
    exp_len = TW'(q.raw) * TW'(q.tbase) * TW'(CYC_W_ONE);
    ro_len = TW'(q.roi) * TW'(q.c1) + TW'(q.c2);
    pace_val = TW'(quo);
    pace_on = q.rate_en && (q.rate != '0);
    trig_edge = q.sync[1] && !q.sync[2];
    ro_load = (exp_cnt == TW'(1)); // readout follows exposure
    // a start may not fall in a running exposure, and the new
    // exposure must outlast the previous readout
    safe = (exp_cnt == '0) && (q.no_ovl ? (ro_cnt <= TW'(1))
         : (ro_cnt <= exp_len));
    // pacing gates only the rise, timed from the previous rise, so a
    // late source does not stretch the period; a rate above the
    // natural maximum leaves the other terms in charge
    pace_ok = !pace_on || (!div_busy && (pace_cnt <= TW'(1)));
    wr_acc = psel && penable && pwrite;
    // safety rechecked so a mode change cannot let a start slip
    acq_start = trig_edge && q.permit && q.hw_en && safe;
    hw_off = wr_acc && (paddr == atg_pkg::A_CTRL)
           && !pwdata[atg_pkg::C_HW];
    permit_nx = q.hw_en && safe && !acq_start && !hw_off
              && (q.permit || pace_ok);
    pace_load = pace_on && permit_nx && !q.permit;
  end

  // ==========================================================
  // read mux and address decode
  always_comb begin
    hit = 1'b1;
    rdata = '0;
    case (paddr)
      atg_pkg::A_CTRL: begin
        rdata[atg_pkg::C_HW] = q.hw_en;
        rdata[atg_pkg::C_NOV] = q.no_ovl;
        rdata[atg_pkg::C_RATE] = q.rate_en;
        rdata[atg_pkg::C_LINE +: atg_pkg::LINE_W] = q.line_sel;
      end
      atg_pkg::A_EXPO: rdata[11:0] = q.raw;
      atg_pkg::A_TBASE: rdata[15:0] = q.tbase;
      atg_pkg::A_ROI: rdata[11:0] = q.roi;
      atg_pkg::A_C1: rdata[15:0] = q.c1;
      atg_pkg::A_C2: rdata[15:0] = q.c2;
      atg_pkg::A_RATE: rdata[15:0] = q.rate;
      atg_pkg::A_STAT: begin
        rdata[4:0] = {q.ovl, pace_cnt != '0, ro_cnt != '0,
                      exp_cnt != '0, q.permit};
      end
      atg_pkg::A_DROP: rdata[15:0] = q.drops;
      default: hit = 1'b0;
    endcase
  end

  // ==========================================================
  // next state
  always_comb begin
    d = q;
    d.sync = {q.sync[1:0], trig_in};
    d.div_go = 1'b0;
    // read data captured in the setup cycle
    if (psel && !penable) begin
      d.prdata = pwrite ? 32'h0 : rdata;
      d.pslverr = !hit;
    end
    if (wr_acc) begin
      case (paddr)
        atg_pkg::A_CTRL: begin
          d.hw_en = pwdata[atg_pkg::C_HW];
          d.no_ovl = pwdata[atg_pkg::C_NOV];
          d.rate_en = pwdata[atg_pkg::C_RATE];
          d.line_sel = pwdata[atg_pkg::C_LINE +: atg_pkg::LINE_W];
        end
        atg_pkg::A_EXPO: begin
          if (pwdata[11:0] >= atg_pkg::RAW_MIN) begin
            d.raw = pwdata[11:0];
          end
        end
        atg_pkg::A_TBASE: begin
          if (pwdata[15:0] >= atg_pkg::TBASE_MIN) begin
            d.tbase = pwdata[15:0];
          end
        end
        atg_pkg::A_ROI: d.roi = pwdata[11:0];
        atg_pkg::A_C1: d.c1 = pwdata[15:0];
        atg_pkg::A_C2: d.c2 = pwdata[15:0];
        atg_pkg::A_RATE: begin
          d.rate = pwdata[15:0];
          d.div_go = 1'b1;
        end
        atg_pkg::A_DROP: d.drops = '0;
        default: d.drops = d.drops;
      endcase
    end
    // dropped triggers count; a drop beats a clear
    if (trig_edge && !acq_start) begin
      d.drops = (wr_acc && paddr == atg_pkg::A_DROP) ? 16'h0001
              : q.drops + 16'h0001;
    end
    // permit falls on start, rises once safe again
    d.permit = permit_nx;
    // period tracking and overlap classification
    if (acq_start) begin
      d.ovl = (q.per_cnt <= q.prev_len);
      d.prev_len = exp_len + ro_len;
      d.per_cnt = TW'(1);
    end else if (q.per_cnt != '1) begin
      d.per_cnt = q.per_cnt + TW'(1);
    end
    // route permit to the selected line
    for (int i = 0; i < atg_pkg::N_LINES; i++) begin
      d.out_line[i] = d.permit && (d.line_sel == i[atg_pkg::LINE_W-1:0]);
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
      q.line_sel <= atg_pkg::RST_LINE;
      q.raw <= atg_pkg::RST_RAW;
      q.tbase <= atg_pkg::RST_TBASE;
      q.roi <= atg_pkg::RST_ROI;
      q.c1 <= atg_pkg::RST_C1;
      q.c2 <= atg_pkg::RST_C2;
      q.rate <= atg_pkg::RST_RATE;
      q.div_go <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // outputs
  assign prdata = q.prdata;
  assign pslverr = q.pslverr & psel & penable;
  assign pready = 1'b1;
  assign acq_permit_out = q.permit;
  assign out_line = q.out_line;
  assign exp_active = (exp_cnt != '0);
  assign ro_active = (ro_cnt != '0);

  // ==========================================================
  // checks
  property p_fall;
    @(posedge mclk) disable iff (!arst_n)
    acq_start |=> !acq_permit_out;
  endproperty
  a_fall: assert property (p_fall) else $error("permit stayed high");

  property p_ignore;
    @(posedge mclk) disable iff (!arst_n)
    (trig_edge && !acq_permit_out && exp_cnt == '0) |=> exp_cnt == '0;
  endproperty
  a_ignore: assert property (p_ignore) else $error("start while low");

  property p_exp_len;
    @(posedge mclk) disable iff (!arst_n)
    acq_start |=> exp_cnt == $past(exp_len);
  endproperty
  a_exp_len: assert property (p_exp_len) else $error("bad exposure");

  property p_ro_len;
    @(posedge mclk) disable iff (!arst_n)
    ro_load |=> ro_cnt == $past(ro_len);
  endproperty
  a_ro_len: assert property (p_ro_len) else $error("bad readout");

  property p_nov;
    @(posedge mclk) disable iff (!arst_n)
    (acq_start && q.no_ovl) |-> ro_cnt == '0 && exp_cnt == '0;
  endproperty
  a_nov: assert property (p_nov) else $error("overlap in no-overlap");

  property p_guard;
    @(posedge mclk) disable iff (!arst_n)
    acq_start |-> exp_cnt == '0 && ro_cnt <= exp_len;
  endproperty
  a_guard: assert property (p_guard) else $error("unsafe start");

  property p_hw;
    @(posedge mclk) disable iff (!arst_n)
    !q.hw_en |=> !acq_permit_out;
  endproperty
  a_hw: assert property (p_hw) else $error("permit while disabled");

  property p_route;
    @(posedge mclk) disable iff (!arst_n)
    out_line == (acq_permit_out ? (4'h1 << q.line_sel) : 4'h0);
  endproperty
  a_route: assert property (p_route) else $error("bad line routing");

  property p_pace;
    @(posedge mclk) disable iff (!arst_n)
    (pace_load && quo >= 32'h4) |=>
      pace_cnt == TW'($past(quo)) && acq_permit_out;
  endproperty
  a_pace: assert property (p_pace) else $error("bad pacing");

  property p_ovl;
    @(posedge mclk) disable iff (!arst_n)
    acq_start |=> q.ovl == ($past(q.per_cnt) <= $past(q.prev_len));
  endproperty
  a_ovl: assert property (p_ovl) else $error("bad overlap flag");
endmodule
`default_nettype wire

// ===== atg_src.sv
/*
  trigger source model: fires on the trigger pin on fire at any time, or on its own when permit is high.
  assumes permit and commands change on mclk rising edges.
*/
`timescale 1ns/1ps
`default_nettype none
module atg_src (
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // control from the bench
  input wire logic auto_en,
  input wire logic fire,
  input wire logic [7:0] lag,
  // gate side
  input wire logic permit,
  output logic trig_in
);
  logic [2:0] hold_q;
  logic [7:0] wait_q;
  logic armed_q;
  // ==========================================================
  // pulse of four cycles so the pin synchroniser sees it
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      hold_q <= 3'h0;
      wait_q <= 8'h00;
      armed_q <= 1'b1;
      trig_in <= 1'b0;
    end else begin
      if (hold_q != 3'h0) hold_q <= hold_q - 3'h1;
      else trig_in <= 1'b0;
      // re-arm only once the gate took the start
      if (!permit) begin
        armed_q <= 1'b1;
        wait_q <= lag;
      end else if (armed_q && auto_en && wait_q != 8'h00) begin
        wait_q <= wait_q - 8'h01; // slow answer
      end
      // automatic start only while permit is high; fire starts at any time
      if (fire || (auto_en && armed_q && permit && wait_q == 8'h00)) begin
        trig_in <= 1'b1;
        hold_q <= 3'h3;
        armed_q <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ===== acquisition_trigger_gate_test.sv
/*
  bench for the trigger gate: apb tasks and frame timing checks.
  assumes atg_src as trigger source and a 100 MHz mclk.
*/
`timescale 1ns/1ps
`default_nettype none
module acquisition_trigger_gate_test;
  // ==========================================================
  // signals
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready, pslverr, trig_in, permit, exp_act, ro_act, err;
  logic [3:0] lines;
  logic auto_en = 1'b0;
  logic fire = 1'b0;
  logic prev_p = 1'b0;
  logic [7:0] lag = 8'h00;
  int n_fail = 0;
  int n_compared = 0;
  int n_exp = 0, n_ro = 0, n_both = 0, n_rise = 0, since = 0, per = 0;

  always #5 mclk = ~mclk;

  atg_gate DUT (.mclk(mclk), .arst_n(arst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .trig_in(trig_in), .acq_permit_out(permit),
    .out_line(lines), .exp_active(exp_act), .ro_active(ro_act));
  atg_src src (.mclk(mclk), .arst_n(arst_n), .auto_en(auto_en),
    .fire(fire), .lag(lag), .permit(permit), .trig_in(trig_in));

  // ==========================================================
  // monitor: activity counts and permit rise spacing
  always @(posedge mclk) begin
    if (exp_act === 1'b1) n_exp++;
    if (ro_act === 1'b1) n_ro++;
    if (exp_act === 1'b1 && ro_act === 1'b1) n_both++;
    since++;
    if (permit === 1'b1 && prev_p !== 1'b1) begin
      per = since;
      since = 0;
      n_rise++;
    end
    prev_p = permit;
  end

  // ==========================================================
  // tasks
  task automatic report_and_stop;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic rng(input string nm, input int lo, input int hi,
                     input int g);
    n_compared++;
    if (g < lo || g > hi) begin
      n_fail++;
      $display("[FAIL] %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask
  // one apb transfer, entered right after a rising edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int i;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge mclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
    if (i == 20) begin
      n_fail++;
      report_and_stop();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk($sformatf("reg %0h", a), e, rd);
  endtask
  task automatic wait_rises(input int k);
    int t;
    int i;
    t = n_rise + k;
    for (i = 0; i < 20000 && n_rise < t; i++) @(posedge mclk);
    if (n_rise < t) begin
      n_fail++;
      report_and_stop();
    end
  endtask
  // mode 0: permit low; mode 1: permit high and nothing active
  task automatic wait_st(input logic m);
    int i;
    for (i = 0; i < 5000; i++) begin
      if (!m && permit === 1'b0) break;
      if (m && permit === 1'b1 && exp_act === 1'b0 && ro_act === 1'b0)
        break;
      @(posedge mclk);
    end
    if (i == 5000) begin
      n_fail++;
      report_and_stop();
    end
  endtask
  task automatic shoot;
    fire <= 1'b1;
    @(posedge mclk);
    fire <= 1'b0;
    @(posedge mclk);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    int t;
    repeat (16) @(posedge mclk);
    arst_n <= 1'b1;
    @(posedge mclk);
    chk("permit rst", 32'h0, {31'h0, permit});
    chk("lines rst", 32'h0, {28'h0, lines});
    rc(atg_pkg::A_CTRL, 32'h20);
    rc(atg_pkg::A_EXPO, 32'h1);
    rc(atg_pkg::A_TBASE, 32'h14);
    rc(atg_pkg::A_ROI, 32'h1E0);
    apb(1'b0, 8'h24, 32'h0);
    chk("slverr", 32'h1, {31'h0, err});
    chk("unmapped", 32'h0, rd);
    wr(atg_pkg::A_EXPO, 32'h0);
    rc(atg_pkg::A_EXPO, 32'h1);
    // exposure 100 cycles, readout 2*10+20 cycles
    wr(atg_pkg::A_TBASE, 32'h1);
    wr(atg_pkg::A_ROI, 32'h2);
    wr(atg_pkg::A_C1, 32'hA);
    wr(atg_pkg::A_C2, 32'h14);
    wr(atg_pkg::A_CTRL, 32'h21);
    wait_st(1'b1);
    chk("line 2", 32'h4, {28'h0, lines});
    wr(atg_pkg::A_CTRL, 32'h11);
    rc(atg_pkg::A_CTRL, 32'h11);
    chk("line 1", 32'h2, {28'h0, lines});
    // one frame, with a second trigger during exposure
    n_exp = 0;
    n_ro = 0;
    shoot();
    wait_st(1'b0);
    chk("exp at start", 32'h1, {31'h0, exp_act});
    shoot();
    wait_st(1'b1);
    rng("exposure", 100, 100, n_exp);
    rng("readout", 40, 40, n_ro);
    rc(atg_pkg::A_DROP, 32'h1);
    wr(atg_pkg::A_DROP, 32'h0);
    rc(atg_pkg::A_DROP, 32'h0);
    // overlapped stream, readout 220 cycles
    wr(atg_pkg::A_ROI, 32'h14);
    auto_en <= 1'b1;
    wait_rises(5);
    rng("period ovl", 220, 232, per);
    rng("overlap seen", 1, 100000, n_both);
    apb(1'b0, atg_pkg::A_STAT, 32'h0);
    chk("ovl flag", 32'h1, {31'h0, rd[4]});
    // no-overlap variant with a slow source
    lag <= 8'd20;
    wr(atg_pkg::A_CTRL, 32'h13);
    wait_rises(2);
    n_both = 0;
    wait_rises(3);
    rng("period novl", 340, 356, per);
    rng("overlap novl", 0, 0, n_both);
    apb(1'b0, atg_pkg::A_STAT, 32'h0);
    chk("novl flag", 32'h0, {31'h0, rd[4]});
    // frame-rate limit of 50000 per second
    lag <= 8'd0;
    wr(atg_pkg::A_ROI, 32'h2);
    wr(atg_pkg::A_RATE, 32'hC350);
    wr(atg_pkg::A_CTRL, 32'h15);
    wait_rises(3);
    rng("period rate", 2000, 2001, per);
    // limit above the natural maximum
    wr(atg_pkg::A_EXPO, 32'h14);
    wr(atg_pkg::A_RATE, 32'hFFFF);
    wait_rises(3);
    rng("period max", 2000, 2012, per);
    // hardware triggering off
    wr(atg_pkg::A_CTRL, 32'h10);
    t = n_rise;
    repeat (3000) @(posedge mclk);
    rng("rises off", t, t, n_rise);
    chk("permit off", 32'h0, {31'h0, permit});
    chk("lines off", 32'h0, {28'h0, lines});
    report_and_stop();
  end
endmodule
`default_nettype wire
